// ===== fcrs_host.sv
`timescale 1ns/10ps

// ==========================================================
// Serial host model: mode 0, clock runs only inside frames
module fcrs_host (
	// Serial link
	output logic      sck,
	output logic      cs_b,
	output logic      dq0,
	input  wire logic dq1
);
	// Idle link: clock low, deselected; scheduled so the frame logic sees the edge
	initial
	begin
		sck <= 1'b0;
		cs_b <= 1'b1;
		dq0 <= 1'b0;
	end

	// One frame; 40 ns half period keeps sck far under every dummy limit
	task automatic xfer(input logic [7:0] op, input logic [15:0] wd, input int n,
		output logic [15:0] rd);
		logic [23:0] sh;
		sh = {op, wd};
		rd = 16'h0000;
		cs_b = 1'b0;
		for (int i = 0; i < 8 + n; i++)
		begin
			dq0 = sh[23 - i];
			#40;
			if (i >= 8)
				rd = {rd[14:0], dq1};
			sck = 1'b1;
			#40;
			sck = 1'b0;
		end
		// Released line shows the inverse, never a stale bit
		dq0 = ~dq0;
		#40;
		cs_b = 1'b1;
		// Deselect gap; a zero-width high pulse would clock the frame logic
		#40;
	endtask
endmodule // fcrs_host

// ===== fcrs_pkg.sv
package fcrs_pkg;

	// ==========================================================
	// Reset values and writable masks
	localparam logic [15:0] NVCR_RESET  = 16'hffff;
	localparam logic [7:0]  VCR_RESET   = 8'hfb;
	localparam logic [7:0]  EXT_RESET   = 8'h00;
	localparam logic [7:0]  EVCR_RESET  = 8'hdf;
	localparam logic [7:0]  VCR_WMASK   = 8'hfb;
	localparam logic [7:0]  EXT_WMASK   = 8'h07;
	localparam logic [7:0]  EVCR_WMASK  = 8'hdf;

	// ==========================================================
	// Field positions
	localparam int NV_DUMMY_LSB  = 12;
	localparam int NV_HOLD       = 4;
	localparam int NV_QUAD       = 3;
	localparam int NV_DUAL       = 2;
	localparam int NV_SEG        = 1;
	localparam int NV_ADDR       = 0;
	localparam int VCR_DUMMY_LSB = 4;
	localparam int VCR_XIP       = 3;
	localparam int EV_QUAD       = 7;
	localparam int EV_DUAL       = 6;
	localparam int EV_HOLD       = 4;
	localparam int EV_ACCEL      = 3;

	// ==========================================================
	// Codes
	localparam logic [1:0]  WRAP_16     = 2'h0;
	localparam logic [1:0]  WRAP_32     = 2'h1;
	localparam logic [1:0]  WRAP_64     = 2'h2;
	localparam logic [1:0]  WRAP_SEQ    = 2'h3;
	localparam logic [31:0] MASK_16     = 32'h0000000f;
	localparam logic [31:0] MASK_32     = 32'h0000001f;
	localparam logic [31:0] MASK_64     = 32'h0000003f;
	localparam logic [31:0] DIE_MASK    = 32'h01ffffff;
	localparam logic [2:0]  SEG_LOWER   = 3'h0;
	localparam logic [2:0]  SEG_UPPER   = 3'h7;
	localparam logic [3:0]  DUMMY_ALT   = 4'h0;
	localparam logic [3:0]  DUMMY_STD   = 4'hf;
	localparam logic [3:0]  DUMMY_DEFAULT = 4'ha;

	// ==========================================================
	// Serial command codes and frame bit counts
	localparam logic [7:0] OP_RD_NV   = 8'h10;
	localparam logic [7:0] OP_WR_NV   = 8'h11;
	localparam logic [7:0] OP_RD_V    = 8'h12;
	localparam logic [7:0] OP_WR_V    = 8'h13;
	localparam logic [7:0] OP_RD_EXT  = 8'h14;
	localparam logic [7:0] OP_WR_EXT  = 8'h15;
	localparam logic [7:0] OP_RD_EV   = 8'h16;
	localparam logic [7:0] OP_WR_EV   = 8'h17;
	localparam logic [5:0] OP_BITS    = 6'h08;
	localparam logic [5:0] LAST_BYTE  = 6'h0f;
	localparam logic [5:0] LAST_WORD  = 6'h17;
	localparam logic [5:0] CNT_MAX    = 6'h3f;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {FCRS_PROTO_EXT, FCRS_PROTO_DUAL, FCRS_PROTO_QUAD} fcrs_proto_t;

	typedef struct packed {
		logic [15:0] nvcr;
		logic [7:0]  vcr;
		logic [7:0]  ext;
		logic [7:0]  evcr;
	} fcrs_regs_t;

	typedef struct packed {
		logic [5:0]  cnt;
		logic [7:0]  op;
		logic [15:0] rx;
		logic [15:0] tx;
		logic        oe;
	} fcrs_link_t;

	typedef struct packed {
		logic        tog;
		logic [7:0]  op;
		logic [15:0] data;
	} fcrs_commit_t;

	typedef struct packed {
		logic        sync_a;
		logic        sync_b;
		logic        seen;
		logic        addr4;
		fcrs_regs_t  regs;
		logic [31:0] rd_addr;
		logic [31:0] pe_addr;
	} fcrs_sys_t;

endpackage

// ===== fcrs_top.sv
`timescale 1ns/10ps

module fcrs_top #(
	parameter bit ALWAYS_DIRECT_EXEC = 1'b0
) (
	// System clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// Serial link from the host
	input  wire logic                  sck,
	input  wire logic                  cs_b,
	input  wire logic                  dq0_in,
	output logic                       dq1_out,
	output logic                       dq1_oe,
	// Boot event and address requests from the array logic
	input  wire logic                  boot_req,
	input  wire logic [31:0]           host_addr,
	input  wire logic                  rd_load,
	input  wire logic                  rd_next,
	input  wire logic                  pe_load,
	// Working configuration
	output logic [31:0]                rd_addr,
	output logic [31:0]                pe_addr,
	output logic [3:0]                 dummy_cycles,
	output fcrs_pkg::fcrs_proto_t      proto,
	output logic                       hold_en,
	output logic                       accel_en,
	output logic                       direct_execution_mode,
	output logic                       addr4_mode
);

	// ==========================================================
	// Helper functions

	// Register contents as shifted out, msb first, left aligned
	function automatic logic [15:0] read_value(input logic [7:0] op,
		input fcrs_pkg::fcrs_regs_t r);
		logic [15:0] v;
		v = 16'h0000;
		case (op)
			fcrs_pkg::OP_RD_NV:  v = r.nvcr;
			fcrs_pkg::OP_RD_V:   v = {r.vcr, 8'h00};
			fcrs_pkg::OP_RD_EXT: v = {r.ext, 8'h00};
			fcrs_pkg::OP_RD_EV:  v = {r.evcr, 8'h00};
			default:             v = 16'h0000;
		endcase
		return v;
	endfunction

	function automatic logic is_read(input logic [7:0] op);
		return (op == fcrs_pkg::OP_RD_NV) || (op == fcrs_pkg::OP_RD_V) ||
			(op == fcrs_pkg::OP_RD_EXT) || (op == fcrs_pkg::OP_RD_EV);
	endfunction

	function automatic logic is_write(input logic [7:0] op);
		return (op == fcrs_pkg::OP_WR_NV) || (op == fcrs_pkg::OP_WR_V) ||
			(op == fcrs_pkg::OP_WR_EXT) || (op == fcrs_pkg::OP_WR_EV);
	endfunction

	// Segment extension supplies the top byte only in 3-byte mode
	function automatic logic [31:0] form_addr(input logic [31:0] a,
		input logic four, input logic [2:0] seg);
		return four ? a : {5'h00, seg, a[23:0]};
	endfunction

	// Increment inside the wrap block, or inside the die
	function automatic logic [31:0] step_addr(input logic [31:0] a,
		input logic [1:0] wrap);
		logic [31:0] m;
		case (wrap)
			fcrs_pkg::WRAP_16: m = fcrs_pkg::MASK_16;
			fcrs_pkg::WRAP_32: m = fcrs_pkg::MASK_32;
			fcrs_pkg::WRAP_64: m = fcrs_pkg::MASK_64;
			default:           m = fcrs_pkg::DIE_MASK;
		endcase
		return (a & ~m) | ((a + 32'h00000001) & m);
	endfunction

	// ==========================================================
	// Link domain: shifting on the host clock

	fcrs_pkg::fcrs_link_t   l;
	fcrs_pkg::fcrs_link_t   next_l;
	fcrs_pkg::fcrs_commit_t c;
	fcrs_pkg::fcrs_commit_t next_c;
	fcrs_pkg::fcrs_sys_t    s;
	fcrs_pkg::fcrs_sys_t    next_s;
	logic                   apply;

	// Frame decode; the register copy is stable whenever a read samples it
	always_comb
	begin
		next_l = l;
		next_c = c;
		next_l.cnt = (l.cnt == fcrs_pkg::CNT_MAX) ? l.cnt : l.cnt + 6'h01;
		next_l.rx = {l.rx[14:0], dq0_in};
		next_l.tx = {l.tx[14:0], 1'b0};
		if (l.cnt < fcrs_pkg::OP_BITS)
			next_l.op = {l.op[6:0], dq0_in};
		if (l.cnt == fcrs_pkg::OP_BITS - 6'h01)
		begin
			next_l.tx = read_value(next_l.op, s.regs);
			next_l.oe = is_read(next_l.op);
		end
		// Last data bit: hold word and flip the event toggle
		if (is_write(l.op) && l.cnt == ((l.op == fcrs_pkg::OP_WR_NV) ?
			fcrs_pkg::LAST_WORD : fcrs_pkg::LAST_BYTE))
		begin
			next_c.tog = ~c.tog;
			next_c.op = l.op;
			next_c.data = (l.op == fcrs_pkg::OP_WR_NV) ? next_l.rx :
				{next_l.rx[7:0], 8'h00};
		end
	end

	// Frame state clears on the rising edge of the frame's own select, no sck edge needed
	always_ff @(posedge sck or posedge cs_b)
	begin
		if (cs_b)
			l <= '0;
		else
			l <= next_l;
	end

	// Commit word survives the frame end; toggle-and-hold crossing
	always_ff @(posedge sck or negedge rst_b)
	begin
		if (!rst_b)
			c <= '0;
		else
			c <= next_c;
	end

	// Read data out, changing after the rising edge
	assign dq1_out = l.tx[15];
	assign dq1_oe  = l.oe;

	// ==========================================================
	// System domain: registers and working configuration

	assign apply = s.sync_b ^ s.seen;

	// Boot reload first, then a landed write so it wins
	always_comb
	begin
		next_s = s;
		next_s.sync_a = c.tog;
		next_s.sync_b = s.sync_a;
		next_s.seen = s.sync_b;
		if (boot_req)
		begin
			next_s.addr4 = ~s.regs.nvcr[fcrs_pkg::NV_ADDR];
			next_s.regs.vcr = {s.regs.nvcr[fcrs_pkg::NV_DUMMY_LSB +: 4], 1'b1, 1'b0,
				fcrs_pkg::WRAP_SEQ};
			next_s.regs.ext = {5'h00, s.regs.nvcr[fcrs_pkg::NV_SEG] ?
				fcrs_pkg::SEG_LOWER : fcrs_pkg::SEG_UPPER};
			next_s.regs.evcr = {s.regs.nvcr[fcrs_pkg::NV_QUAD],
				s.regs.nvcr[fcrs_pkg::NV_DUAL], 1'b0,
				s.regs.nvcr[fcrs_pkg::NV_HOLD], 1'b1, s.regs.evcr[2:0]};
		end
		if (apply)
		begin
			case (c.op)
				fcrs_pkg::OP_WR_NV:  next_s.regs.nvcr = c.data;
				fcrs_pkg::OP_WR_V:   next_s.regs.vcr = c.data[15:8] & fcrs_pkg::VCR_WMASK;
				fcrs_pkg::OP_WR_EXT: next_s.regs.ext = c.data[15:8] & fcrs_pkg::EXT_WMASK;
				fcrs_pkg::OP_WR_EV:  next_s.regs.evcr = c.data[15:8] & fcrs_pkg::EVCR_WMASK;
				default:             next_s.regs = s.regs;
			endcase
		end
		// Read pointer; the segment register is never touched here
		if (rd_load)
			next_s.rd_addr = form_addr(host_addr, s.addr4, s.regs.ext[2:0]);
		else if (rd_next)
			next_s.rd_addr = step_addr(s.rd_addr, s.regs.vcr[1:0]);
		if (pe_load)
			next_s.pe_addr = form_addr(host_addr, s.addr4, s.regs.ext[2:0]);
	end

	// State register; reset models the factory-fresh power-on
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.regs.nvcr <= fcrs_pkg::NVCR_RESET;
			s.regs.vcr <= fcrs_pkg::VCR_RESET;
			s.regs.ext <= fcrs_pkg::EXT_RESET;
			s.regs.evcr <= fcrs_pkg::EVCR_RESET;
		end
		else
			s <= next_s;
	end

	// ==========================================================
	// Working configuration outputs

	// Dummy code decode; both end codes mean the default count
	always_comb
	begin
		if (s.regs.vcr[7:4] == fcrs_pkg::DUMMY_ALT || s.regs.vcr[7:4] == fcrs_pkg::DUMMY_STD)
			dummy_cycles = fcrs_pkg::DUMMY_DEFAULT;
		else
			dummy_cycles = s.regs.vcr[7:4];
	end

	// Quad beats dual when both are selected
	always_comb
	begin
		if (!s.regs.evcr[fcrs_pkg::EV_QUAD])
			proto = fcrs_pkg::FCRS_PROTO_QUAD;
		else if (!s.regs.evcr[fcrs_pkg::EV_DUAL])
			proto = fcrs_pkg::FCRS_PROTO_DUAL;
		else
			proto = fcrs_pkg::FCRS_PROTO_EXT;
	end

	assign hold_en = s.regs.evcr[fcrs_pkg::EV_HOLD];
	assign accel_en = ~s.regs.evcr[fcrs_pkg::EV_ACCEL];
	assign direct_execution_mode = ALWAYS_DIRECT_EXEC | ~s.regs.vcr[fcrs_pkg::VCR_XIP];
	assign addr4_mode = s.addr4;
	assign rd_addr = s.rd_addr;
	assign pe_addr = s.pe_addr;

	// ==========================================================
	// Assertions

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	property p_hold_boot;
		boot_req && !apply |=> hold_en == $past(s.regs.nvcr[4]);
	endproperty
	a_hold_boot: assert property (p_hold_boot) else $error("hold enable not loaded");

	property p_quad_wins;
		boot_req && !apply && s.regs.nvcr[3:2] == 2'h0 |=> proto == fcrs_pkg::FCRS_PROTO_QUAD;
	endproperty
	a_quad_wins: assert property (p_quad_wins) else $error("quad did not win");

	property p_seg_boot;
		boot_req && !apply |=> s.regs.ext[2:0] == ($past(s.regs.nvcr[1]) ? 3'h0 : 3'h7);
	endproperty
	a_seg_boot: assert property (p_seg_boot) else $error("segment default wrong");

	property p_addr4_boot;
		boot_req |=> addr4_mode == !$past(s.regs.nvcr[0]);
	endproperty
	a_addr4_boot: assert property (p_addr4_boot) else $error("address length wrong");

	property p_dummy;
		apply && c.op == fcrs_pkg::OP_WR_V && c.data[15:12] != 4'h0 && c.data[15:12] != 4'hf
			|=> dummy_cycles == $past(c.data[15:12]);
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy count not applied");

	property p_wrap16;
		rd_next && !rd_load && s.regs.vcr[1:0] == 2'h0 |=>
			rd_addr[31:4] == $past(rd_addr[31:4]) &&
			rd_addr[3:0] == $past(rd_addr[3:0]) + 4'h1;
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("16-byte wrap broken");

	property p_die;
		rd_next && !rd_load && s.regs.vcr[1:0] == 2'h3 |=>
			rd_addr[31:25] == $past(rd_addr[31:25]) ##1 s.regs.ext == $past(s.regs.ext, 2)
			|| $past(apply) || $past(boot_req)
			|| $past(apply, 2) || $past(boot_req, 2);
	endproperty
	a_die: assert property (p_die) else $error("read left its die");

	property p_ext_used;
		rd_load && !addr4_mode |=> rd_addr == {5'h00, $past(s.regs.ext[2:0]), $past(host_addr[23:0])};
	endproperty
	a_ext_used: assert property (p_ext_used) else $error("segment not applied");

	property p_ext_ignored;
		pe_load && addr4_mode |=> pe_addr == $past(host_addr);
	endproperty
	a_ext_ignored: assert property (p_ext_ignored) else $error("segment not ignored");

	property p_reserved;
		s.regs.ext[7:3] == 5'h00 && s.regs.vcr[2] == 1'b0 && s.regs.evcr[5] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_write_lands;
		$changed(c.tog) |-> ##[2:4] apply;
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write event lost");

	property p_read_drive;
		@(posedge sck) disable iff (cs_b) l.cnt == 6'h08 |-> dq1_oe == is_read(l.op);
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read drive wrong");

	// ==========================================================
	// Runtime write checks, then the 64-byte wrap; expectations come from the written word, or prior values for the power-on write and wrap

	property p_ev_quad;
		apply && c.op == fcrs_pkg::OP_WR_EV && !c.data[15] |=>
			proto == fcrs_pkg::FCRS_PROTO_QUAD;
	endproperty
	a_ev_quad: assert property (p_ev_quad) else $error("quad select not applied");

	property p_ev_dual;
		apply && c.op == fcrs_pkg::OP_WR_EV && c.data[15:14] == 2'h2 |=>
			proto == fcrs_pkg::FCRS_PROTO_DUAL;
	endproperty
	a_ev_dual: assert property (p_ev_dual) else $error("dual select not applied");

	property p_ev_hold;
		apply && c.op == fcrs_pkg::OP_WR_EV |=> hold_en == $past(c.data[12]);
	endproperty
	a_ev_hold: assert property (p_ev_hold) else $error("hold enable not written");

	property p_ev_accel;
		apply && c.op == fcrs_pkg::OP_WR_EV |=> accel_en == !$past(c.data[11]);
	endproperty
	a_ev_accel: assert property (p_ev_accel) else $error("acceleration gate wrong");

	property p_dummy_default;
		apply && c.op == fcrs_pkg::OP_WR_V && (c.data[15:12] == 4'h0 ||
			c.data[15:12] == 4'hf) |=> dummy_cycles == fcrs_pkg::DUMMY_DEFAULT;
	endproperty
	a_dummy_default: assert property (p_dummy_default) else $error("dummy default wrong");

	property p_direct;
		apply && c.op == fcrs_pkg::OP_WR_V |=>
			direct_execution_mode == (ALWAYS_DIRECT_EXEC || !$past(c.data[11]));
	endproperty
	a_direct: assert property (p_direct) else $error("direct execution wrong");

	property p_nv_deferred;
		apply && c.op == fcrs_pkg::OP_WR_NV && !boot_req |=>
			addr4_mode == $past(addr4_mode) && proto == $past(proto);
	endproperty
	a_nv_deferred: assert property (p_nv_deferred) else $error("early power-on effect");

	property p_wrap64;
		rd_next && !rd_load && s.regs.vcr[1:0] == 2'h2 |=>
			rd_addr[31:6] == $past(rd_addr[31:6]) &&
			rd_addr[5:0] == $past(rd_addr[5:0]) + 6'h01;
	endproperty
	a_wrap64: assert property (p_wrap64) else $error("64-byte wrap broken");

	c_write_v: cover property (apply && c.op == fcrs_pkg::OP_WR_V);
	c_wrap_turn: cover property (rd_next && s.regs.vcr[1:0] == 2'h0 && rd_addr[3:0] == 4'hf);
	c_quad_boot: cover property (boot_req && s.regs.nvcr[3:2] == 2'h0);
	c_dual_write: cover property (apply && c.op == fcrs_pkg::OP_WR_EV && c.data[15:14] == 2'h2);
	c_die_turn: cover property (rd_next && s.regs.vcr[1:0] == 2'h3 && &rd_addr[24:0]);

endmodule // fcrs_top

// ===== tb.sv
`timescale 1ns/10ps

// ==========================================================
// Testbench
module tb;
	// Design and bench signals
	logic                  sys_clk;
	logic                  rst_b;
	logic                  sck;
	logic                  cs_b;
	logic                  dq0;
	logic                  dq1;
	logic                  dq1_out;
	logic                  dq1_oe;
	logic                  boot_req;
	logic [31:0]           host_addr;
	logic                  rd_load;
	logic                  rd_next;
	logic                  pe_load;
	logic [31:0]           rd_addr;
	logic [31:0]           pe_addr;
	logic [3:0]            dummy_cycles;
	fcrs_pkg::fcrs_proto_t proto;
	logic                  hold_en;
	logic                  accel_en;
	logic                  direct_execution_mode;
	logic                  addr4_mode;
	int                    errors;
	int                    check_count;
	int                    cyc;
	logic [3:0]            dcode [4] = '{4'h0, 4'h1, 4'he, 4'hf};
	logic [3:0]            dexp [4] = '{4'ha, 4'h1, 4'he, 4'ha};
	logic [31:0]           wnext [3] = '{32'h10, 32'h0, 32'h20};

	// Undriven pin shows the inverse, so a late enable is caught
	assign dq1 = dq1_oe ? dq1_out : ~dq1_out;

	fcrs_top #(.ALWAYS_DIRECT_EXEC(1'b0)) u_fcrs_top (
		.sys_clk(sys_clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .dq0_in(dq0),
		.dq1_out(dq1_out), .dq1_oe(dq1_oe), .boot_req(boot_req), .host_addr(host_addr),
		.rd_load(rd_load), .rd_next(rd_next), .pe_load(pe_load), .rd_addr(rd_addr),
		.pe_addr(pe_addr), .dummy_cycles(dummy_cycles), .proto(proto), .hold_en(hold_en),
		.accel_en(accel_en), .direct_execution_mode(direct_execution_mode),
		.addr4_mode(addr4_mode)
	);

	fcrs_host u_fcrs_host (.sck(sck), .cs_b(cs_b), .dq0(dq0), .dq1(dq1));

	// System clock
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Hang guard, well above the two thousand or so cycles needed
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			end_sim();
		end
	end

	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// Write frame, then room for the sys side to land it
	task automatic wr(input logic [7:0] op, input logic [15:0] d, input int n);
		logic [15:0] r;
		u_fcrs_host.xfer(op, d, n, r);
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] op, input int n, input logic [15:0] e);
		logic [15:0] r;
		u_fcrs_host.xfer(op, 16'h0000, n, r);
		check(32'(r), 32'(e));
	endtask

	// One-cycle address request pulse
	task automatic addr_op(input logic ld, input logic nx, input logic pe, input logic [31:0] a);
		@(posedge sys_clk);
		rd_load <= ld;
		rd_next <= nx;
		pe_load <= pe;
		host_addr <= a;
		@(posedge sys_clk);
		rd_load <= 1'b0;
		rd_next <= 1'b0;
		pe_load <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic ev_case(input logic [7:0] w, input logic [1:0] p, input logic h,
		input logic a);
		wr(fcrs_pkg::OP_WR_EV, {w, 8'h00}, 8);
		rd(fcrs_pkg::OP_RD_EV, 8, {8'h00, w & 8'hdf});
		check(32'(proto), 32'(p));
		check(32'(hold_en), 32'(h));
		check(32'(accel_en), 32'(a));
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		rst_b <= 1'b0;
		boot_req = 1'b0;
		host_addr = 32'h0;
		rd_load = 1'b0;
		rd_next = 1'b0;
		pe_load = 1'b0;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(negedge sys_clk);
		check(32'(dummy_cycles), 32'ha);
		check(32'(direct_execution_mode), 32'h0);
		check(32'(addr4_mode), 32'h0);
		rd(fcrs_pkg::OP_RD_NV, 16, 16'hffff);
		rd(fcrs_pkg::OP_RD_V, 8, 16'h00fb);
		rd(fcrs_pkg::OP_RD_EXT, 8, 16'h0000);
		rd(fcrs_pkg::OP_RD_EV, 8, 16'h00df);
		$display("test reset done");
		// Dummy codes, reserved bit written high
		for (int i = 0; i < 4; i++)
		begin
			wr(fcrs_pkg::OP_WR_V, {dcode[i], 4'h7, 8'h00}, 8);
			rd(fcrs_pkg::OP_RD_V, 8, {8'h00, dcode[i], 4'h3});
			check(32'(dummy_cycles), 32'(dexp[i]));
			check(32'(direct_execution_mode), 32'h1);
		end
		$display("test dummy done");
		// Wrap modes from start 31
		for (int w = 0; w < 3; w++)
		begin
			wr(fcrs_pkg::OP_WR_V, {4'ha, 2'h2, 2'(w), 8'h00}, 8);
			addr_op(1'b1, 1'b0, 1'b0, 32'h1f);
			check(rd_addr, 32'h1f);
			addr_op(1'b0, 1'b1, 1'b0, 32'h0);
			check(rd_addr, wnext[w]);
		end
		wr(fcrs_pkg::OP_WR_V, 16'hfb00, 8);
		check(32'(direct_execution_mode), 32'h0);
		$display("test wrap done");
		// Segment select and die wrap
		wr(fcrs_pkg::OP_WR_EXT, 16'hf900, 8);
		rd(fcrs_pkg::OP_RD_EXT, 8, 16'h0001);
		addr_op(1'b1, 1'b0, 1'b0, 32'h00ffffff);
		check(rd_addr, 32'h01ffffff);
		addr_op(1'b0, 1'b1, 1'b0, 32'h0);
		check(rd_addr, 32'h00000000);
		rd(fcrs_pkg::OP_RD_EXT, 8, 16'h0001);
		addr_op(1'b0, 1'b0, 1'b1, 32'hff123456);
		check(pe_addr, 32'h01123456);
		$display("test segment done");
		ev_case(8'h7f, 2'h2, 1'b1, 1'b0);
		ev_case(8'hbf, 2'h1, 1'b1, 1'b0);
		ev_case(8'hff, 2'h0, 1'b1, 1'b0);
		ev_case(8'he7, 2'h0, 1'b0, 1'b1);
		$display("test enhanced done");
		// Power-on register takes effect only at boot
		wr(fcrs_pkg::OP_WR_NV, 16'h5fe0, 16);
		rd(fcrs_pkg::OP_RD_NV, 16, 16'h5fe0);
		check(32'(proto), 32'h0);
		check(32'(addr4_mode), 32'h0);
		@(posedge sys_clk);
		boot_req <= 1'b1;
		@(posedge sys_clk);
		boot_req <= 1'b0;
		repeat (2) @(negedge sys_clk);
		check(32'(proto), 32'h2);
		check(32'(addr4_mode), 32'h1);
		check(32'(hold_en), 32'h0);
		check(32'(dummy_cycles), 32'h5);
		rd(fcrs_pkg::OP_RD_V, 8, 16'h005b);
		rd(fcrs_pkg::OP_RD_EXT, 8, 16'h0007);
		addr_op(1'b0, 1'b0, 1'b1, 32'h12345678);
		check(pe_addr, 32'h12345678);
		addr_op(1'b1, 1'b0, 1'b0, 32'h03ffffff);
		addr_op(1'b0, 1'b1, 1'b0, 32'h0);
		check(rd_addr, 32'h02000000);
		$display("test boot done");
		end_sim();
	end
endmodule // tb
